// *** rtl/ddr_lp_consts.svh ***
`ifndef DDR_LP_CONSTS_SVH
`define DDR_LP_CONSTS_SVH
// register indices
`define REG_LP_SELECT 4'h0
`define REG_SELF_REFRESH_REQ 4'h1
`define REG_PAD_CTRL 4'h2
`define REG_PHY_RST 4'h3
`define REG_STATUS 4'h4
// low-power select codes (one-hot; LP_NONE is all zero)
`define LP_PD 5'h10
`define LP_PD_CG 5'h08
`define LP_SR 5'h04
`define LP_SR_CG 5'h02
`define LP_SR_CCG 5'h01
`define LP_NONE 5'h00
// pad control fields
`define PAD_EN_BIT 0
`define PAD_SREN_BIT 1
`define PAD_RSTEN_BIT 2
`define PAD_DQSDIS_BIT 3
`define PAD_RESET 4'h1
`endif

// *** rtl/ddr_lp_pkg.sv ***
package ddr_lp_pkg;
  typedef enum logic [2:0] {
    ST_NORMAL, ST_PD, ST_PD_CG, ST_SR, ST_SR_CG, ST_SR_CCG
  } lp_state_t;
  typedef struct packed {
    logic mem_clk_en;
    logic mem_cke;
    logic self_refresh;
    logic ctrl_clk_gated;
  } mem_ctl_t;
endpackage

// *** rtl/ddr_low_power_mode_control.sv ***
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "ddr_lp_consts.svh"
// How it works
// - five low-power states; power-down loses data, self-refresh keeps it
// - code 0x10 is power-down, 0x08 power-down with memory clock gated
// - code 0x04 is self-refresh, 0x02 self-refresh with clock gated
// - code 0x01 is lpddr only and refused from a software write
module ddr_low_power_mode_control
  import ddr_lp_pkg::*;
#(
  parameter bit IS_LPDDR = 1'b1
)
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic auto_deep_lp_i,
  output logic [7:0] rdata_o,
  output mem_ctl_t mem_ctl_o,
  output logic cmd_hold_o,
  output logic data_retained_o,
  output logic [3:0] pad_ctrl_o,
  output logic phy_rst_o
);

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  logic [4:0] low_power_select_field_q;
  logic self_refresh_request_q;
  logic [3:0] pad_q;
  logic phy_rst_q;
  lp_state_t state_q;
  lp_state_t state_d;

  function automatic logic is_onehot0(input logic [4:0] v);
    return (v & (v - 5'h01)) == 5'h00;
  endfunction

  // the 0x01 code may only come from the hardware deep-sleep path
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      low_power_select_field_q <= `LP_NONE;
    else if (wr_i && addr_i == `REG_LP_SELECT)
    begin
      // illegal multi-bit and manual 0x01 writes are ignored
      if (is_onehot0(wdata_i[4:0])
          && wdata_i[4:0] != `LP_SR_CCG)
        low_power_select_field_q <= wdata_i[4:0];
    end
    else if (auto_deep_lp_i && IS_LPDDR
             && low_power_select_field_q == `LP_NONE)
      low_power_select_field_q <= `LP_SR_CCG;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      self_refresh_request_q <= 1'b0;
    else if (wr_i && addr_i == `REG_SELF_REFRESH_REQ)
      self_refresh_request_q <= wdata_i[0];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pad_q <= `PAD_RESET;
    else if (wr_i && addr_i == `REG_PAD_CTRL)
      pad_q <= wdata_i[3:0];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      phy_rst_q <= 1'b0;
    else if (wr_i && addr_i == `REG_PHY_RST)
      phy_rst_q <= wdata_i[0];
  end

  // ------------------------------------------------------------
  // low-power state
  // ------------------------------------------------------------
  always_comb
  begin
    unique case (low_power_select_field_q)
      `LP_PD: state_d = ST_PD;
      `LP_PD_CG: state_d = ST_PD_CG;
      `LP_SR: state_d = ST_SR;
      `LP_SR_CG: state_d = ST_SR_CG;
      `LP_SR_CCG: state_d = ST_SR_CCG;
      default: state_d = ST_NORMAL;
    endcase
    // a pending self-refresh request turns the normal state into self-refresh
    if (state_d == ST_NORMAL && self_refresh_request_q)
      state_d = ST_SR;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_q <= ST_NORMAL;
    else
      state_q <= state_d;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mem_ctl_o <= '{mem_clk_en: 1'b1, mem_cke: 1'b1,
                     self_refresh: 1'b0, ctrl_clk_gated: 1'b0};
      cmd_hold_o <= 1'b0;
      data_retained_o <= 1'b1;
    end
    else
    begin
      mem_ctl_o.mem_clk_en <= !(state_d inside {ST_PD_CG, ST_SR_CG,
                                                ST_SR_CCG});
      mem_ctl_o.mem_cke <= state_d == ST_NORMAL;
      mem_ctl_o.self_refresh <= state_d inside {ST_SR, ST_SR_CG,
                                                ST_SR_CCG};
      mem_ctl_o.ctrl_clk_gated <= state_d == ST_SR_CCG;
      cmd_hold_o <= state_d != ST_NORMAL;
      data_retained_o <= !(state_d inside {ST_PD, ST_PD_CG});
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pad_ctrl_o <= `PAD_RESET;
      phy_rst_o <= 1'b0;
    end
    else
    begin
      pad_ctrl_o <= pad_q;
      phy_rst_o <= phy_rst_q;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      unique case (addr_i)
        `REG_LP_SELECT: rdata_o <= {3'h0, low_power_select_field_q};
        `REG_SELF_REFRESH_REQ: rdata_o <= {7'h00, self_refresh_request_q};
        `REG_PAD_CTRL: rdata_o <= {4'h0, pad_q};
        `REG_PHY_RST: rdata_o <= {7'h00, phy_rst_q};
        `REG_STATUS: rdata_o <= {4'h0, data_retained_o, cmd_hold_o,
                                 mem_ctl_o.self_refresh, mem_ctl_o.mem_cke};
        default: rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_no_manual_deep: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (wr_i && addr_i == `REG_LP_SELECT && wdata_i[4:0] == `LP_SR_CCG)
    |=> low_power_select_field_q != `LP_SR_CCG
    || $past(low_power_select_field_q) == `LP_SR_CCG)
    else $error("manual write entered deep mode");
  a_select_onehot: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    is_onehot0(low_power_select_field_q))
    else $error("select not one-hot");
  a_hold_active: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (low_power_select_field_q != `LP_NONE) |=> cmd_hold_o)
    else $error("commands not held in low power");
  a_hold_release: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (low_power_select_field_q == `LP_NONE && !self_refresh_request_q)
    |=> !cmd_hold_o)
    else $error("hold stuck after exit");
  a_pd_clk_gate: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (low_power_select_field_q == `LP_PD_CG) |=> !mem_ctl_o.mem_clk_en
    && !mem_ctl_o.self_refresh)
    else $error("power-down clock gate wrong");
  a_pd_plain: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (low_power_select_field_q == `LP_PD) |=> mem_ctl_o.mem_clk_en
    && !data_retained_o)
    else $error("plain power-down wrong");
  a_sr_gate: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (low_power_select_field_q == `LP_SR_CG) |=> mem_ctl_o.self_refresh
    && !mem_ctl_o.mem_clk_en && !mem_ctl_o.ctrl_clk_gated)
    else $error("self-refresh gated wrong");
  a_sr_plain: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (low_power_select_field_q == `LP_SR) |=> mem_ctl_o.self_refresh
    && mem_ctl_o.mem_clk_en && data_retained_o)
    else $error("self-refresh wrong");
  a_pad_readback: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (wr_i && addr_i == `REG_PAD_CTRL) ##1 (rd_i && addr_i == `REG_PAD_CTRL)
    |=> rdata_o[3:0] == $past(wdata_i[3:0], 2))
    else $error("pad read-back mismatch");
  c_self_refresh_request_forced: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    self_refresh_request_q && low_power_select_field_q == `LP_NONE);
  c_pd_loss: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !data_retained_o && cmd_hold_o);
  c_enter_sr_cg: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mem_ctl_o.self_refresh && !mem_ctl_o.mem_clk_en);
  c_deep: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mem_ctl_o.ctrl_clk_gated);
  c_exit: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cmd_hold_o ##1 !cmd_hold_o);
endmodule

// *** test/ddr_mem_model.sv ***
`timescale 1ns/10ps
module ddr_mem_model
  import ddr_lp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire mem_ctl_t mem_ctl_i,
  output logic contents_ok_o
);
  // contents survive only while refreshed; power-down loses them
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      contents_ok_o <= 1'b1;
    else if (!mem_ctl_i.mem_cke && !mem_ctl_i.self_refresh)
      contents_ok_o <= 1'b0;
  end
endmodule

// *** test/tb_ddr_low_power_mode_control.sv ***
`timescale 1ns/10ps
`include "ddr_lp_consts.svh"
module tb_ddr_low_power_mode_control;
  import ddr_lp_pkg::*;
  logic sys_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, auto_deep_lp_i = 0;
  logic [3:0] addr_i = 4'h0, pad_ctrl_o;
  logic [7:0] wdata_i = 8'h00, rdata_o, rd_v;
  mem_ctl_t mem_ctl_o;
  logic cmd_hold_o, data_retained_o, phy_rst_o, ok;
  int bad_count = 0, num_checks = 0;
  logic [31:0] lfsr = 32'hF75FD254;
  logic [4:0] codes [4] = '{`LP_PD, `LP_PD_CG, `LP_SR, `LP_SR_CG};
  always #2.5 sys_clk_i = ~sys_clk_i;
  ddr_low_power_mode_control DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .auto_deep_lp_i(auto_deep_lp_i), .rdata_o(rdata_o),
    .mem_ctl_o(mem_ctl_o), .cmd_hold_o(cmd_hold_o),
    .data_retained_o(data_retained_o), .pad_ctrl_o(pad_ctrl_o),
    .phy_rst_o(phy_rst_o));
  ddr_mem_model mem (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .mem_ctl_i(mem_ctl_o), .contents_ok_o(ok));
  // expected {clk_en, cke, self_refresh, ctrl_gated, hold, retained}
  function automatic logic [5:0] exp_of(input logic [4:0] c);
    case (c)
      `LP_PD: return 6'h22;
      `LP_PD_CG: return 6'h02;
      `LP_SR: return 6'h2B;
      `LP_SR_CG: return 6'h0B;
      `LP_SR_CCG: return 6'h0F;
      default: return 6'h31;
    endcase
  endfunction
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 rd_v = rdata_o;
  endtask
  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 rd_v = rdata_o;
  endtask
  task automatic chk_state(input logic [4:0] c);
    chk({2'b0, mem_ctl_o, cmd_hold_o, data_retained_o}, {2'b0, exp_of(c)});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    finish_test();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    #1 chk_state(`LP_NONE);
    chk({4'h0, pad_ctrl_o}, 8'h01);
    $display("reset values done");
    foreach (codes[i])
    begin
      wr(`REG_LP_SELECT, {3'b0, codes[i]});
      chk_state(codes[i]);
      rd(`REG_LP_SELECT);
      chk(rd_v, {3'b0, codes[i]});
      wr(`REG_LP_SELECT, 8'h00);
      chk_state(`LP_NONE);
    end
    chk({7'b0, ok}, 8'h00);
    $display("mode table done");
    wr(`REG_LP_SELECT, {3'b0, `LP_SR_CCG});
    chk_state(`LP_NONE);
    wr(`REG_LP_SELECT, 8'h06);
    chk_state(`LP_NONE);
    @(posedge sys_clk_i);
    auto_deep_lp_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 chk_state(`LP_SR_CCG);
    rd(`REG_STATUS);
    chk(rd_v, 8'h0E);
    @(posedge sys_clk_i);
    auto_deep_lp_i <= 1'b0;
    $display("refusals done");
    // entry to self-refresh with clock gated, then the exit order
    wr(`REG_LP_SELECT, {3'b0, `LP_SR_CG});
    wr(`REG_SELF_REFRESH_REQ, 8'h01);
    chk_state(`LP_SR_CG);
    wr(`REG_PAD_CTRL, 8'h0E);
    chk({4'h0, pad_ctrl_o}, 8'h0E);
    wr(`REG_PHY_RST, 8'h01);
    chk({7'b0, phy_rst_o}, 8'h01);
    wr(`REG_PHY_RST, 8'h00);
    chk({7'b0, phy_rst_o}, 8'h00);
    wr(`REG_PAD_CTRL, 8'h00);
    wr(`REG_LP_SELECT, 8'h00);
    chk_state(`LP_SR);
    wr(`REG_SELF_REFRESH_REQ, 8'h00);
    wr_rd(`REG_PAD_CTRL, 8'h01);
    chk(rd_v, 8'h01);
    chk_state(`LP_NONE);
    $display("exit sequence done");
    repeat (20)
    begin
      lfsr = next_rand(lfsr);
      wr(`REG_PAD_CTRL, {4'h0, lfsr[3:0]});
      chk({4'h0, pad_ctrl_o}, {4'h0, lfsr[3:0]});
      rd(lfsr[8] ? 4'hF : `REG_PAD_CTRL);
      chk(rd_v, lfsr[8] ? 8'h00 : {4'h0, lfsr[3:0]});
    end
    $display("random pads done");
    finish_test();
  end
endmodule
